// file: rtl/tws_pkg.sv
/*
 tws_pkg: constants for the two-wire slave transmitter end block.
 Assumes a 10 MHz system clock and an AXI4-Lite master.
*/
package tws_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_OWN_ADDR = 8'h08;
   localparam logic [7:0] OFS_DATA     = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   // control bit positions
   localparam int BIT_FLAG  = 7;
   localparam int BIT_ACKEN = 6;
   localparam int BIT_START = 5;
   localparam int BIT_STOP  = 4;
   localparam int BIT_WCOL  = 3;
   localparam int BIT_EN    = 2;
   // interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR  = 1;
   // reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [1:0] RST_IRQ  = 2'h0;
   // ------------------------------------------------------------
   // status codes and bus constants
   // ------------------------------------------------------------
   localparam logic [7:0] CODE_SLA_R   = 8'hA8;
   localparam logic [7:0] CODE_TX_ACK  = 8'hB8;
   localparam logic [7:0] CODE_TX_NACK = 8'hC0;
   localparam logic [7:0] CODE_LAST    = 8'hC8;
   localparam logic [7:0] CODE_GC      = 8'h70;
   localparam logic [7:0] CODE_NO_INFO = 8'hF8;
   localparam logic [7:0] CODE_BUS_ERR = 8'h00;
   localparam logic [7:0] CODE_START   = 8'h08;
   localparam logic [7:0] CODE_RSTART  = 8'h10;
   localparam logic [7:0] GC_ADDR      = 8'h00;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int SYS_CLK_KHZ   = 10000;
   localparam int START_HOLD_NS = 4000;
   localparam logic [6:0] HOLD_CYC  = 7'((START_HOLD_NS * SYS_CLK_KHZ + 999999) / 1000000);
   localparam logic [6:0] HOLD2_CYC = 7'(2 * HOLD_CYC);
   // engine states
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_TX, ST_TACK, ST_TWAIT, ST_ERR,
      ST_MSTART, ST_MOWN, ST_MRSTA, ST_MSTOP
   } tws_state_t;
endpackage : tws_pkg

// file: rtl/tws_tx_end.sv
/*
 tws_tx_end: two-wire slave transmitter end states, bus error and
 repeated-start bus ownership, with AXI4-Lite registers.
 Assumes open-drain pins resolved outside; SCL well below CLK/16.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
// Summary of operation
// - NACK after byte gives code C0
// - ACK after final byte gives C8
// - ack_enable 0 then ignore all addresses
// - ack_enable 1 then own address, gated general call
// - start_request then START once bus free
// - flag clear shows code F8
// - misplaced START/STOP is bus error, code 00
// - bus error sets job_done_flag
// - recovery goes idle, clears stop bit only
// - recovery releases lines, sends no STOP
// - repeated START keeps bus ownership
// - own address LSB enables general call
// - flag cleared only by writing one
// - flag set stretches SCL low, except in the bus error state
`timescale 1ns/1ns
module tws_tx_end
   import tws_pkg::*;
(
   // clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_I,
   // axi4-lite write
   input  wire logic [7:0]  S_AXI_AWADDR_I,
   input  wire logic        S_AXI_AWVALID_I,
   output wire logic        S_AXI_AWREADY_O,
   input  wire logic [31:0] S_AXI_WDATA_I,
   input  wire logic [3:0]  S_AXI_WSTRB_I,
   input  wire logic        S_AXI_WVALID_I,
   output wire logic        S_AXI_WREADY_O,
   output wire logic [1:0]  S_AXI_BRESP_O,
   output wire logic        S_AXI_BVALID_O,
   input  wire logic        S_AXI_BREADY_I,
   // axi4-lite read
   input  wire logic [7:0]  S_AXI_ARADDR_I,
   input  wire logic        S_AXI_ARVALID_I,
   output wire logic        S_AXI_ARREADY_O,
   output wire logic [31:0] S_AXI_RDATA_O,
   output wire logic [1:0]  S_AXI_RRESP_O,
   output wire logic        S_AXI_RVALID_O,
   input  wire logic        S_AXI_RREADY_I,
   // two-wire pins
   input  wire logic        SCL_I,
   output wire logic        SCL_O,
   output wire logic        SCL_OE_O,
   input  wire logic        SDA_I,
   output wire logic        SDA_O,
   output wire logic        SDA_OE_O,
   // interrupt
   output wire logic        IRQ_O
);
   import tws_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic        aw_got, w_got, aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, w_lane;
   logic [7:0]  aw_addr, w_data;
   logic [1:0]  b_resp, r_resp;
   logic [31:0] r_data;
   logic        scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic        flag, ack_enable, start_request, stop_request, enable, wcol;
   logic [1:0]  psc, irq_stat, irq_mask;
   logic [7:0]  own_addr, data_reg, code, shreg;
   tws_state_t  state;
   logic [2:0]  cnt;
   logic [6:0]  tmr;
   logic        last_byte, gc_hit, sda_oe, mscl, scl_oe, master_own;
   logic        bus_busy, ev_done, ev_err, irq;

   // ------------------------------------------------------------
   // pin synchronisers and bus events
   // ------------------------------------------------------------
   // scl_m and sda_m feed only the second stage
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end
      else
      begin
         {scl_m, scl_s, scl_d} <= {SCL_I, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {SDA_I, sda_m, sda_s};
      end
   end

   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire start_det = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   wire aw_hs       = S_AXI_AWVALID_I & aw_rdy;
   wire w_hs        = S_AXI_WVALID_I & w_rdy;
   wire ar_hs       = S_AXI_ARVALID_I & ar_rdy;
   wire do_wr       = aw_got & w_got & ~b_vld;
   wire next_aw_got = (aw_got | aw_hs) & ~do_wr;
   wire next_w_got  = (w_got | w_hs) & ~do_wr;
   wire next_b_vld  = do_wr | (b_vld & ~S_AXI_BREADY_I);
   wire next_r_vld  = ar_hs | (r_vld & ~S_AXI_RREADY_I);

   // write decode; only byte lane 0 carries register bits
   wire wr_en     = do_wr & w_lane;
   wire wr_ctrl   = wr_en & (aw_addr == OFS_CTRL);
   wire wr_status = wr_en & (aw_addr == OFS_STATUS);
   wire wr_own    = wr_en & (aw_addr == OFS_OWN_ADDR);
   wire wr_data   = wr_en & (aw_addr == OFS_DATA);
   wire wr_istat  = wr_en & (aw_addr == OFS_IRQ_STAT);
   wire wr_imask  = wr_en & (aw_addr == OFS_IRQ_MASK);
   wire wr_hit    = (aw_addr == OFS_CTRL) | (aw_addr == OFS_STATUS) | (aw_addr == OFS_OWN_ADDR) |
                    (aw_addr == OFS_DATA) | (aw_addr == OFS_IRQ_STAT) | (aw_addr == OFS_IRQ_MASK);
   wire clr_wr    = wr_ctrl & w_data[BIT_FLAG];

   // read decode; status shows F8 whenever the flag is down
   // no-info code
   wire [7:0] status_view = flag ? code : CODE_NO_INFO;
   wire [7:0] ctrl_view   = {flag, ack_enable, start_request, stop_request, wcol, enable, 2'h0};
   wire       rd_hit      = (S_AXI_ARADDR_I == OFS_CTRL) | (S_AXI_ARADDR_I == OFS_STATUS) |
                            (S_AXI_ARADDR_I == OFS_OWN_ADDR) | (S_AXI_ARADDR_I == OFS_DATA) |
                            (S_AXI_ARADDR_I == OFS_IRQ_STAT) | (S_AXI_ARADDR_I == OFS_IRQ_MASK);
   wire [7:0] rd_val      = (S_AXI_ARADDR_I == OFS_CTRL)     ? ctrl_view :
                            (S_AXI_ARADDR_I == OFS_STATUS)   ? {status_view[7:3], 1'b0, psc} :
                            (S_AXI_ARADDR_I == OFS_OWN_ADDR) ? own_addr :
                            (S_AXI_ARADDR_I == OFS_DATA)     ? data_reg :
                            (S_AXI_ARADDR_I == OFS_IRQ_STAT) ? {6'h00, irq_stat} :
                            (S_AXI_ARADDR_I == OFS_IRQ_MASK) ? {6'h00, irq_mask} : 8'h00;

   // channel handshakes; one write and one read in flight
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         {aw_got, w_got, aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, w_lane} <= 8'h00;
         {aw_addr, w_data} <= 16'h0000;
         {b_resp, r_resp} <= 4'h0;
         r_data <= 32'h0000_0000;
      end
      else
      begin
         aw_got <= next_aw_got;
         w_got  <= next_w_got;
         b_vld  <= next_b_vld;
         r_vld  <= next_r_vld;
         aw_rdy <= ~next_aw_got & ~next_b_vld;
         w_rdy  <= ~next_w_got & ~next_b_vld;
         ar_rdy <= ~next_r_vld;
         if (aw_hs)
            aw_addr <= S_AXI_AWADDR_I;
         if (w_hs)
            {w_lane, w_data} <= {S_AXI_WSTRB_I[0], S_AXI_WDATA_I[7:0]};
         if (do_wr)
            b_resp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         if (ar_hs)
         begin
            r_data <= {24'h00_0000, rd_val};
            r_resp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   // data writes are refused while the engine owns the byte
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         {ack_enable, start_request, enable, wcol} <= 4'h0;
         {own_addr, data_reg} <= {RST_REG8, RST_REG8};
         {psc, irq_stat, irq_mask} <= {RST_IRQ, RST_IRQ, RST_IRQ};
      end
      else
      begin
         if (wr_ctrl)
            {ack_enable, start_request, enable} <= {w_data[BIT_ACKEN], w_data[BIT_START], w_data[BIT_EN]};
         if (wr_status)
            psc <= w_data[1:0];
         if (wr_own)
            own_addr <= w_data;
         if (wr_data)
            wcol <= ~flag;
         if (wr_data & flag)
            data_reg <= w_data;
         if (wr_imask)
            irq_mask <= w_data[1:0];
         // new events win over a write-one clear
         irq_stat <= (irq_stat & ~(wr_istat ? w_data[1:0] : 2'h0)) | {ev_err, ev_done};
      end
   end

   // ------------------------------------------------------------
   // serial engine
   // ------------------------------------------------------------
   wire [7:0] addr_byte = {shreg[6:0], sda_s};
   wire own_match = ack_enable & (addr_byte[7:1] == own_addr[7:1]) & addr_byte[0];
   wire gc_match  = ack_enable & own_addr[0] & (addr_byte == GC_ADDR);
   wire in_frame  = ((state == ST_ADDR) & (cnt != 3'h0)) | (state == ST_AACK) |
                    (state == ST_TX) | (state == ST_TACK);
   wire bus_err   = (start_det | stop_det) & in_frame;
   wire tx_over   = gc_hit | (code == CODE_TX_NACK) | (code == CODE_LAST);

   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         state <= ST_IDLE;
         {cnt, tmr, shreg, code} <= 26'h000_0000;
         {flag, stop_request, last_byte, gc_hit, sda_oe, mscl} <= 6'h00;
         {master_own, bus_busy, ev_done, ev_err} <= 4'h0;
      end
      else
      begin
         ev_done <= 1'b0;
         ev_err  <= 1'b0;
         if (clr_wr)
            flag <= 1'b0;
         if (wr_ctrl)
            stop_request <= w_data[BIT_STOP];
         if (start_det)
            bus_busy <= 1'b1;
         else if (stop_det)
            bus_busy <= 1'b0;
         if (!enable)
         begin
            state      <= ST_IDLE;
            sda_oe     <= 1'b0;
            mscl       <= 1'b0;
            master_own <= 1'b0;
         end
         else if (bus_err)
         begin
            state  <= ST_ERR;
            sda_oe <= 1'b0;
            flag   <= 1'b1;
            code   <= CODE_BUS_ERR;
            ev_err <= 1'b1;
         end
         else
         begin
            unique case (state)
               ST_IDLE:
               begin
                  sda_oe <= 1'b0;
                  if (start_det)
                     {state, cnt} <= {ST_ADDR, 3'h0};
                  else if (start_request & ~flag & ~bus_busy)
                     {state, tmr, sda_oe} <= {ST_MSTART, 7'h00, 1'b1};
               end
               ST_ADDR:
               begin
                  if (start_det)
                     cnt <= 3'h0;
                  else if (stop_det)
                     state <= ST_IDLE;
                  else if (scl_rise)
                  begin
                     shreg  <= addr_byte;
                     cnt    <= cnt + 3'h1;
                     gc_hit <= gc_match;
                     if (cnt == 3'h7)
                        state <= (own_match | gc_match) ? ST_AACK : ST_IDLE;
                  end
               end
               ST_AACK:
                  if (scl_fall)
                  begin
                     cnt    <= 3'h1;
                     sda_oe <= (cnt == 3'h0);
                     if (cnt != 3'h0)
                     begin
                        {flag, ev_done, state} <= {2'h3, ST_TWAIT};
                        code <= gc_hit ? CODE_GC : CODE_SLA_R;
                     end
                  end
               ST_TX:
                  if (scl_fall)
                  begin
                     if (cnt == 3'h7)
                        {sda_oe, state} <= {1'b0, ST_TACK};
                     else
                     begin
                        cnt    <= cnt + 3'h1;
                        shreg  <= {shreg[6:0], 1'b0};
                        sda_oe <= ~shreg[6];
                     end
                  end
               ST_TACK:
                  if (scl_rise)
                  begin
                     {flag, ev_done, state} <= {2'h3, ST_TWAIT};
                     code <= sda_s ? CODE_TX_NACK : (last_byte ? CODE_LAST : CODE_TX_ACK);
                  end
               ST_TWAIT:
                  if (start_det)
                     {state, cnt} <= {ST_ADDR, 3'h0};
                  else if (stop_det)
                     state <= ST_IDLE;
                  else if (!flag & !scl_s)
                  begin
                     if (tx_over)
                        state <= ST_IDLE;
                     else
                     begin
                        {shreg, cnt, state} <= {data_reg, 3'h0, ST_TX};
                        last_byte <= ~ack_enable;
                        sda_oe    <= ~data_reg[7];
                     end
                  end
               ST_ERR:
               begin
                  {sda_oe, mscl, master_own} <= 3'h0;
                  if (!flag)
                     {state, stop_request} <= {ST_IDLE, 1'b0};
               end
               ST_MSTART:
               begin
                  tmr <= tmr + 7'h01;
                  if (tmr == HOLD_CYC)
                  begin
                     {mscl, flag, ev_done, master_own, state} <= {4'hF, ST_MOWN};
                     code <= master_own ? CODE_RSTART : CODE_START;
                  end
               end
               ST_MOWN:
                  if (!flag)
                  begin
                     tmr <= 7'h00;
                     if (stop_request)
                        {state, sda_oe} <= {ST_MSTOP, 1'b1};
                     else if (start_request)
                        {state, sda_oe} <= {ST_MRSTA, 1'b0};
                  end
               ST_MRSTA:
               begin
                  tmr <= tmr + 7'h01;
                  if (tmr == HOLD_CYC)
                     mscl <= 1'b0;
                  if (tmr == HOLD2_CYC)
                     {state, tmr, sda_oe} <= {ST_MSTART, 7'h00, 1'b1};
               end
               ST_MSTOP:
               begin
                  tmr <= tmr + 7'h01;
                  if (tmr == HOLD_CYC)
                     mscl <= 1'b0;
                  if (tmr == HOLD2_CYC)
                     {sda_oe, stop_request, master_own, state} <= {3'h0, ST_IDLE};
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // clock stretch and interrupt outputs
   // ------------------------------------------------------------
   // stretch while flagged outside ST_ERR; waits for scl low to avoid a glitch
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         {scl_oe, irq} <= 2'h0;
      else
      begin
         scl_oe <= mscl | (enable & flag & (state != ST_ERR) & (scl_oe | ~scl_s));
         irq    <= |(irq_stat & irq_mask);
      end
   end

   assign S_AXI_AWREADY_O = aw_rdy;
   assign S_AXI_WREADY_O  = w_rdy;
   assign S_AXI_BRESP_O   = b_resp;
   assign S_AXI_BVALID_O  = b_vld;
   assign S_AXI_ARREADY_O = ar_rdy;
   assign S_AXI_RDATA_O   = r_data;
   assign S_AXI_RRESP_O   = r_resp;
   assign S_AXI_RVALID_O  = r_vld;
   assign SCL_O           = 1'b0;
   assign SCL_OE_O        = scl_oe;
   assign SDA_O           = 1'b0;
   assign SDA_OE_O        = sda_oe;
   assign IRQ_O           = irq;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   // nack gives C0
   nack_code_a : assert property (
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (enable && !bus_err && state == ST_TACK && scl_rise && sda_s) |=> (flag && code == CODE_TX_NACK))
      else $error("nack after byte not reported as C0");
   final_ack_a : assert property (
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (enable && !bus_err && state == ST_TACK && scl_rise && !sda_s && last_byte) |=> (code == CODE_LAST))
      else $error("ack after final byte not reported as C8");
   ignore_addr_a : assert property (
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (enable && !bus_err && state == ST_ADDR && scl_rise && cnt == 3'h7 && !ack_enable) |=> state == ST_IDLE)
      else $error("address answered while ack_enable low");
   no_info_a : assert property (
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (ar_hs && S_AXI_ARADDR_I == OFS_STATUS && !flag) |=> (S_AXI_RDATA_O[7:3] == CODE_NO_INFO[7:3]))
      else $error("status not F8 with flag low");
   bus_err_a : assert property (
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (enable && bus_err) |=> (flag && code == CODE_BUS_ERR && state == ST_ERR) [*2])
      else $error("bus error not flagged with code 00");
   err_release_a : assert property (
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (state == ST_ERR && $past(state) == ST_ERR) |-> (!SDA_OE_O && !mscl))
      else $error("lines driven during bus error");
   recover_a : assert property (
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (enable && state == ST_ERR && !flag && !wr_ctrl) |=> (state == ST_IDLE && !stop_request))
      else $error("bus error recovery incomplete");
   stretch_a : assert property (
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (enable && flag && !clr_wr && state == ST_TWAIT && !scl_s) |=> SCL_OE_O)
      else $error("scl not held low while flag set");
   flag_hold_a : assert property (
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (flag && !clr_wr) |=> flag)
      else $error("flag cleared without software write");

endmodule : tws_tx_end

// file: bench/tws_bus_model.sv
/*
 tws_bus_model: behavioural two-wire master on the far side of the block.
 Assumes the bench resolves both lines as wired-and with pull-ups.
*/
`timescale 1ns/1ns
module tws_bus_model (
   // resolved bus lines
   input  wire logic scl_i,
   input  wire logic sda_i,
   // this master's drives, high = released
   output logic      scl_o,
   output logic      sda_o
);
   // both lines released while idle, so the clock stands still between frames
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic start();
      #13 sda_o = 1'b0;
      #400 sda_o = 1'b0;
   endtask : start
   // bit slot waits out clock stretching before sampling
   task automatic bit_io(input logic b, output logic r);
      scl_o = 1'b0;
      #200 sda_o = b;
      #200 scl_o = 1'b1;
      wait (scl_i);
      r = sda_i;
      #400 scl_o = 1'b0;
   endtask : bit_io
   task automatic byte_io(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r[i]);
   endtask : byte_io
   // stop condition, also used mid-byte to break the frame
   task automatic stop();
      scl_o = 1'b0;
      #200 sda_o = 1'b0;
      #200 scl_o = 1'b1;
      #400 sda_o = 1'b1;
      #400 sda_o = 1'b1;
   endtask : stop
endmodule : tws_bus_model

// file: bench/test_tws_tx_end.sv
/*
 test_tws_tx_end: self-checking bench for the slave transmitter end states.
 Assumes tws_bus_model as far-side master and pull-ups on both lines.
*/
`timescale 1ns/1ns
module test_tws_tx_end;
   import tws_pkg::*;
   logic        clk, rst, awv, wv, bry, arv, rry, a;
   logic [7:0]  awa, ara, q, d, own_slave_address;
   logic [31:0] wd;
   logic [1:0]  rsp;
   int          err_total, comparisons;
   wire logic   bv, aw, ww, ar, rv, scl_oe, sda_oe, irq, scl_m, sda_m, so, sdo;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdat;
   // wired-and resolution with pull-ups
   wire logic   scl = scl_m & (scl_oe ? so : 1'b1);
   wire logic   sda = sda_m & (sda_oe ? sdo : 1'b1);
   tws_tx_end u_dut (.CLK_SYS_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
      .S_AXI_AWREADY_O(aw), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
      .S_AXI_WREADY_O(ww), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
      .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(ar), .S_AXI_RDATA_O(rdat),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .SCL_I(scl), .SCL_O(so),
      .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sdo), .SDA_OE_O(sda_oe), .IRQ_O(irq));
   tws_bus_model u_bus (.scl_i(scl), .sda_i(sda), .scl_o(scl_m), .sda_o(sda_m));
   // expected control byte, engine always enabled
   function automatic logic [7:0] ctl(input logic f, input logic ak, input logic p);
      ctl = (8'(f) << BIT_FLAG) | (8'(ak) << BIT_ACKEN) | (8'(p) << BIT_STOP) | (8'h01 << BIT_EN);
   endfunction : ctl
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // write: address and data offered together, bready held until the answer
   task automatic wr(input logic [7:0] ad, input logic [7:0] v);
      @(posedge clk);
      awa <= ad;
      wd  <= {24'h0, v};
      awv <= 1'b1;
      wv  <= 1'b1;
      bry <= 1'b1;
      do
      begin
         @(posedge clk);
         if (aw) awv <= 1'b0;
         if (ww) wv <= 1'b0;
      end
      while (!bv);
      chk({6'h0, bresp}, {6'h0, RESP_OKAY});
      bry <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] ad, output logic [7:0] v);
      @(posedge clk);
      ara <= ad;
      arv <= 1'b1;
      rry <= 1'b1;
      do
      begin
         @(posedge clk);
         if (ar) arv <= 1'b0;
      end
      while (!rv);
      v = rdat[7:0];
      rsp = rresp;
      rry <= 1'b0;
   endtask : rd
   // status with prescaler masked; settle time covers the pin synchronisers
   task automatic st(input logic [7:0] exp);
      repeat (8) @(posedge clk);
      rd(OFS_STATUS, q);
      chk(q & 8'hF8, exp);
   endtask : st
   task automatic print_verdict();
      $display("Comparisons %0d, errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // watchdog at 2 ms, far beyond the roughly 80 microseconds the run needs
   initial
   begin
      #2000000 err_total++;
      print_verdict();
   end
   initial
   begin
      {awv, wv, bry, arv, rry} = 5'h00;
      awa = 8'h00;
      ara = 8'h00;
      wd  = 32'h0;
      rst = 1'b1;
      void'($urandom(32'h6b78d6e1));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      st(CODE_NO_INFO);
      rd(8'h1C, q);
      chk({6'h0, rsp}, {6'h0, RESP_SLVERR});
      own_slave_address = 8'($urandom_range(1, 127));
      wr(OFS_OWN_ADDR, {own_slave_address[6:0], 1'b1});
      wr(OFS_IRQ_MASK, 8'h03);
      for (int r = 0; r < 2; r++)
      begin
         wr(OFS_CTRL, ctl(0, 1, 0));
         u_bus.start();
         u_bus.byte_io({own_slave_address[6:0], 1'b1}, q);
         u_bus.bit_io(1'b1, a);
         chk({7'h0, a}, 8'h00);
         st(CODE_SLA_R);
         d = 8'($urandom);
         wr(OFS_DATA, d);
         wr(OFS_CTRL, ctl(1, 0, 0));
         u_bus.byte_io(8'hFF, q);
         chk(q, d);
         u_bus.bit_io(r == 0, a);
         st(r ? CODE_LAST : CODE_TX_NACK);
         chk({7'h0, irq}, 8'h01);
         wr(OFS_CTRL, ctl(1, r[0], 0));
         wr(OFS_IRQ_STAT, 8'h03);
         // the interrupt output trails its status register by one cycle
         repeat (2) @(posedge clk);
         chk({7'h0, irq}, 8'h00);
         u_bus.byte_io(8'hFF, q);
         chk(q, 8'hFF);
         u_bus.bit_io(1'b1, a);
         u_bus.stop();
         if (r == 0)
         begin
            u_bus.start();
            u_bus.byte_io({own_slave_address[6:0], 1'b1}, q);
            u_bus.bit_io(1'b1, a);
            chk({7'h0, a}, 8'h01);
            u_bus.stop();
            st(CODE_NO_INFO);
         end
      end
      // stop condition three bits into an address byte
      u_bus.start();
      repeat (3) u_bus.bit_io(1'b0, a);
      u_bus.stop();
      st(CODE_BUS_ERR);
      rd(OFS_CTRL, q);
      chk(q, ctl(1, 1, 0));
      wr(OFS_CTRL, ctl(1, 1, 1));
      rd(OFS_CTRL, q);
      chk(q, ctl(0, 1, 0));
      chk({6'h0, scl_oe, sda_oe}, 8'h00);
      st(CODE_NO_INFO);
      print_verdict();
   end
endmodule : test_tws_tx_end
